// file: logic/sil_pkg.sv
// Package with register map, field layout and timing for the interrupt logic.
package sil_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] ADDR_INT_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_INT_SOURCE = 8'h01;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h02;
  localparam logic [7:0] ADDR_WIN_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_WIN_REF_MSB = 8'h04;
  localparam logic [7:0] ADDR_WIN_REF_LSB = 8'h05;
  localparam logic [7:0] ADDR_WIN_RANGE = 8'h06;
  localparam logic [7:0] ADDR_FIFO_THS = 8'h07;

  // Pin configuration field positions.
  localparam int CFG_MODE_BIT = 0;
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_DRIVE_BIT = 2;
  localparam int CFG_EN_BIT = 3;

  // Source and status bit positions.
  localparam int SRC_DRDY = 0;
  localparam int SRC_FULL = 1;
  localparam int SRC_THS = 2;
  localparam int SRC_WIN = 3;
  localparam int STAT_POR = 4;

  // Window configuration: top reference bit and sample-count limit.
  localparam int WCFG_REF16_BIT = 7;
  localparam int WCFG_CNT_LSB = 0;
  localparam int WCFG_CNT_W = 2;

  // Reset values.
  localparam logic [7:0] INT_CONFIG_RST = 8'h00;
  localparam logic [7:0] INT_SOURCE_RST = 8'h00;
  localparam logic [7:0] WIN_CONFIG_RST = 8'h00;
  localparam logic [7:0] WIN_BYTE_RST = 8'h00;

  // Widths.
  localparam int PRESS_W = 17;
  localparam int RANGE_W = 8;

  // Pin timing, nanoseconds, and clock period.
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_PULSE_NS = 500;
  localparam int T_DEASSERT_NS = 500;
  localparam logic [7:0] PULSE_CYC =
    8'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] GAP_CYC =
    8'((T_DEASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register access carried from the port to the register file.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sil_bus_s;

  // Pin timer states.
  typedef enum logic [2:0] {
    PIN_IDLE = 3'b001,
    PIN_ON = 3'b010,
    PIN_GAP = 3'b100
  } sil_pin_e;

endpackage

// file: logic/sil_window.sv
// Pressure window check with consecutive out-of-window sample counter.
`timescale 1ns/1ps
module sil_window (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Configuration
  input wire logic [sil_pkg::PRESS_W-1:0] ref_p,
  input wire logic [sil_pkg::RANGE_W-1:0] range_p,
  input wire logic [sil_pkg::WCFG_CNT_W-1:0] cnt_lim,
  // Samples
  input wire logic sample_valid,
  input wire logic [sil_pkg::PRESS_W-1:0] sample_p,
  // Result, a one-cycle event per qualifying sample
  output logic fire
);

  logic [sil_pkg::PRESS_W+1:0] hi_w, lo_w, smp_w;
  logic outside;
  logic [sil_pkg::WCFG_CNT_W:0] run_q;

  // Bounds are widened so reference plus range cannot wrap.
  assign hi_w = {2'b00, ref_p} + {11'h000, range_p};
  assign lo_w = {2'b00, ref_p} - {11'h000, range_p};
  assign smp_w = {2'b00, sample_p};
  // Below-zero lower bound shows as a set top bit and is never exceeded.
  assign outside = (smp_w > hi_w) ||
    (!lo_w[sil_pkg::PRESS_W+1] && smp_w < lo_w);

  // Count consecutive outside samples; an inside sample restarts the run.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      run_q <= '0;
      fire <= 1'b0;
    end
    else
    begin
      fire <= 1'b0;
      if (sample_valid)
      begin
        if (!outside)
        begin
          run_q <= '0;
        end
        else if (run_q < {1'b0, cnt_lim})
        begin
          run_q <= run_q + 3'h1;
          fire <= (run_q + 3'h1) >= {1'b0, cnt_lim};
        end
        else
        begin
          fire <= 1'b1;
        end
      end
    end
  end

  fire_after_out_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fire |-> $past(sample_valid) && $past(outside))
    else $error("window event without outside sample");

endmodule

// file: logic/sil_pin.sv
// Interrupt pin timer for pulsed and latched modes with gap enforcement.
`timescale 1ns/1ps
module sil_pin (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control
  input wire logic latched,
  input wire logic rise,
  input wire logic level,
  input wire logic force_off,
  // Logical pin state
  output logic active
);

  sil_pkg::sil_pin_e st_q;
  logic [7:0] cnt_q;
  logic pend_q;

  // Pulses last the pulse time; every release is followed by the gap.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      st_q <= sil_pkg::PIN_IDLE;
      cnt_q <= 8'h00;
      pend_q <= 1'b0;
    end
    else
    begin
      pend_q <= 1'b0;
      unique case (st_q)
        sil_pkg::PIN_IDLE:
        begin
          // A rise seen during the gap is served here, not dropped.
          if (!force_off && (latched ? level : (rise || pend_q)))
          begin
            st_q <= sil_pkg::PIN_ON;
            cnt_q <= 8'h01;
          end
        end
        sil_pkg::PIN_ON:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (force_off ||
              (latched ? !level : cnt_q >= sil_pkg::PULSE_CYC))
          begin
            st_q <= sil_pkg::PIN_GAP;
            cnt_q <= 8'h01;
          end
        end
        sil_pkg::PIN_GAP:
        begin
          cnt_q <= cnt_q + 8'h01;
          pend_q <= !force_off && !latched && (pend_q || rise);
          if (cnt_q >= sil_pkg::GAP_CYC)
          begin
            st_q <= sil_pkg::PIN_IDLE;
          end
        end
      endcase
    end
  end

  assign active = (st_q == sil_pkg::PIN_ON);

  gap_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(active) && !force_off |-> !active [*5])
    else $error("pin reasserted inside gap");

endmodule

// file: logic/sil_top.sv
// Sensor interrupt logic: window detector, status register and pin.
`timescale 1ns/1ps
// Operation
// - Hold 17-bit pressure reference in three fields.
// - Hold 8-bit window half-width.
// - Outside means strictly beyond reference plus/minus width.
// - Fire after configured consecutive outside samples.
// - Refire after each further outside sample.
// - Set power-up flag on leaving reset.
// - Power-up never drives the pin.
// - Status read clears power-up flag.
// - Pin polarity, drive and mode configurable.
// - Pin carries OR of enabled sources.
// - Pulsed mode: one pulse per rising condition.
// - Pulsed mode keeps minimum gap.
// - Latched mode holds pin, keeps gap.
// - Latched FIFO interrupt follows its condition.
// - Latched ready/window release on status read.
// - FIFO disable or flush clears FIFO interrupts.
// - Flush also clears window interrupt.
// - Threshold rewrite releases pin, clears threshold status.
// - Status clears by read, by FIFO disable or flush, and by threshold rewrite.
// - Latched threshold interrupt reasserts after rewrite if its condition holds.
// - FIFO conditions asserted at measurement end.
// - Ready asserted when new results present.
// - Sources gated by enables, power-up always.
module sil_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Measurement and FIFO events from the core
  input wire logic meas_done,
  input wire logic [16:0] meas_press,
  input wire logic fifo_full_cond,
  input wire logic fifo_ths_cond,
  input wire logic fifo_enabled,
  input wire logic fifo_flush,
  // Interrupt pin, two signals
  output logic int_pin_o,
  output logic int_pin_oe_n,
  // Threshold value for the FIFO
  output logic [7:0] fifo_ths_q
);

  sil_pkg::sil_bus_s bus;
  logic [7:0] int_config_q, int_source_q, win_config_q;
  logic [7:0] ref_msb_q, ref_lsb_q, range_q;
  logic [4:0] status_q;
  logic full_prev_q, ths_prev_q;
  logic full_rise, ths_rise, win_fire, flush_any, ths_wr, stat_rd;
  logic [3:0] cond, cond_prev_q;
  logic level, rise, pin_active, pin_lvl;
  logic drdy_lat_q, win_lat_q;
  logic por_done_q;

  // Returns true when a strobe addresses the given register.
  function automatic logic hit(input logic stb, input logic [7:0] a,
                               input logic [7:0] target);
    hit = stb && (a == target);
  endfunction

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign stat_rd = hit(bus.rd, bus.addr, sil_pkg::ADDR_INT_STATUS);
  assign ths_wr = hit(bus.wr, bus.addr, sil_pkg::ADDR_FIFO_THS);
  assign flush_any = fifo_flush || !fifo_enabled;

  // Configuration registers written by software.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      int_config_q <= sil_pkg::INT_CONFIG_RST;
      int_source_q <= sil_pkg::INT_SOURCE_RST;
      win_config_q <= sil_pkg::WIN_CONFIG_RST;
      ref_msb_q <= sil_pkg::WIN_BYTE_RST;
      ref_lsb_q <= sil_pkg::WIN_BYTE_RST;
      range_q <= sil_pkg::WIN_BYTE_RST;
      fifo_ths_q <= sil_pkg::WIN_BYTE_RST;
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        sil_pkg::ADDR_INT_CONFIG: int_config_q <= {4'h0, bus.wdata[3:0]};
        sil_pkg::ADDR_INT_SOURCE: int_source_q <= {4'h0, bus.wdata[3:0]};
        sil_pkg::ADDR_WIN_CONFIG: win_config_q <= bus.wdata;
        sil_pkg::ADDR_WIN_REF_MSB: ref_msb_q <= bus.wdata;
        sil_pkg::ADDR_WIN_REF_LSB: ref_lsb_q <= bus.wdata;
        sil_pkg::ADDR_WIN_RANGE: range_q <= bus.wdata;
        sil_pkg::ADDR_FIFO_THS: fifo_ths_q <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Window detector on each finished measurement.
  sil_window u_window (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ref_p({win_config_q[sil_pkg::WCFG_REF16_BIT], ref_msb_q, ref_lsb_q}),
    .range_p(range_q),
    .cnt_lim(win_config_q[sil_pkg::WCFG_CNT_LSB +: sil_pkg::WCFG_CNT_W]),
    .sample_valid(meas_done && int_source_q[sil_pkg::SRC_WIN]),
    .sample_p(meas_press),
    .fire(win_fire)
  );

  // FIFO conditions are sampled at measurement end and follow their level.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      full_prev_q <= 1'b0;
      ths_prev_q <= 1'b0;
    end
    else
    begin
      if (flush_any)
      begin
        full_prev_q <= 1'b0;
        ths_prev_q <= 1'b0;
      end
      else
      begin
        full_prev_q <= meas_done ? fifo_full_cond
                                 : full_prev_q && fifo_full_cond;
        ths_prev_q <= ths_wr ? fifo_ths_cond
          : meas_done ? fifo_ths_cond
                      : ths_prev_q && fifo_ths_cond;
      end
    end
  end
  assign full_rise = meas_done && fifo_full_cond && !full_prev_q;
  assign ths_rise = meas_done && fifo_ths_cond && !ths_prev_q;

  // Sticky status; a set in the same cycle as a clearing read wins.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      status_q <= 5'h00;
      por_done_q <= 1'b0;
    end
    else
    begin
      // Power-up is set once, on the first edge after reset only.
      por_done_q <= 1'b1;
      if (!por_done_q)
      begin
        status_q[sil_pkg::STAT_POR] <= 1'b1;
      end
      else if (stat_rd)
      begin
        status_q[sil_pkg::STAT_POR] <= 1'b0;
      end
      status_q[sil_pkg::SRC_DRDY] <= (meas_done &&
        int_source_q[sil_pkg::SRC_DRDY]) ||
        (status_q[sil_pkg::SRC_DRDY] && !stat_rd);
      status_q[sil_pkg::SRC_WIN] <= !flush_any && (win_fire ||
        (status_q[sil_pkg::SRC_WIN] && !stat_rd));
      status_q[sil_pkg::SRC_FULL] <= !flush_any &&
        ((full_prev_q && int_source_q[sil_pkg::SRC_FULL]) ||
        (status_q[sil_pkg::SRC_FULL] && !stat_rd));
      status_q[sil_pkg::SRC_THS] <= !flush_any && !ths_wr &&
        ((ths_prev_q && int_source_q[sil_pkg::SRC_THS]) ||
        (status_q[sil_pkg::SRC_THS] && !stat_rd));
    end
  end

  // Latched holders for ready and window, released by a status read.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      drdy_lat_q <= 1'b0;
      win_lat_q <= 1'b0;
    end
    else
    begin
      drdy_lat_q <= meas_done || (drdy_lat_q && !stat_rd);
      win_lat_q <= !flush_any &&
        (win_fire || (win_lat_q && !stat_rd));
    end
  end

  // Enabled conditions; power-up deliberately excluded from the pin.
  assign cond[sil_pkg::SRC_DRDY] = drdy_lat_q &&
    int_source_q[sil_pkg::SRC_DRDY];
  assign cond[sil_pkg::SRC_FULL] = full_prev_q && !flush_any &&
    int_source_q[sil_pkg::SRC_FULL];
  assign cond[sil_pkg::SRC_THS] = ths_prev_q && !flush_any &&
    int_source_q[sil_pkg::SRC_THS];
  assign cond[sil_pkg::SRC_WIN] = win_lat_q &&
    int_source_q[sil_pkg::SRC_WIN];
  assign level = |cond;

  // Rising edges of any enabled source trigger a pulse.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      cond_prev_q <= 4'h0;
    end
    else
    begin
      cond_prev_q <= cond;
    end
  end
  assign rise = |(cond & ~cond_prev_q) ||
    (win_fire && int_source_q[sil_pkg::SRC_WIN]) ||
    (meas_done && int_source_q[sil_pkg::SRC_DRDY]);

  // Pin sequencer applies pulse length and deassertion gap.
  sil_pin u_pin (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .latched(int_config_q[sil_pkg::CFG_MODE_BIT]),
    .rise(rise),
    .level(level),
    .force_off(ths_wr || fifo_flush),
    .active(pin_active)
  );

  // Pin drive from flip-flops: polarity and push-pull or open-drain.
  assign pin_lvl = int_config_q[sil_pkg::CFG_EN_BIT] && pin_active;
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      int_pin_o <= 1'b0;
      int_pin_oe_n <= 1'b1;
    end
    else
    begin
      int_pin_o <= pin_lvl ^ !int_config_q[sil_pkg::CFG_POL_BIT];
      if (int_config_q[sil_pkg::CFG_DRIVE_BIT])
      begin
        // Open-drain drives only the low level of the pin and releases it otherwise.
        int_pin_oe_n <= pin_lvl ^ !int_config_q[sil_pkg::CFG_POL_BIT];
      end
      else
      begin
        int_pin_oe_n <= 1'b0;
      end
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (bus.rd)
    begin
      unique case (bus.addr)
        sil_pkg::ADDR_INT_CONFIG: reg_rdata <= int_config_q;
        sil_pkg::ADDR_INT_SOURCE: reg_rdata <= int_source_q;
        sil_pkg::ADDR_INT_STATUS: reg_rdata <= {3'h0, status_q};
        sil_pkg::ADDR_WIN_CONFIG: reg_rdata <= win_config_q;
        sil_pkg::ADDR_WIN_REF_MSB: reg_rdata <= ref_msb_q;
        sil_pkg::ADDR_WIN_REF_LSB: reg_rdata <= ref_lsb_q;
        sil_pkg::ADDR_WIN_RANGE: reg_rdata <= range_q;
        sil_pkg::ADDR_FIFO_THS: reg_rdata <= fifo_ths_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // Named steps of a status read clearing ready.
  sequence drdy_set_s;
    status_q[sil_pkg::SRC_DRDY] && !meas_done;
  endsequence
  sequence drdy_read_s;
    stat_rd;
  endsequence

  drdy_read_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    drdy_set_s and drdy_read_s |=> !status_q[sil_pkg::SRC_DRDY])
    else $error("ready status not cleared by read");
  por_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |=> status_q[sil_pkg::STAT_POR])
    else $error("power-up flag not set");
  flush_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    flush_any |=> !status_q[sil_pkg::SRC_WIN] && !status_q[sil_pkg::SRC_FULL])
    else $error("flush left status set");
  ths_wr_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ths_wr |=> !status_q[sil_pkg::SRC_THS])
    else $error("threshold status survived rewrite");
  pin_off_dis_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !int_config_q[sil_pkg::CFG_EN_BIT] && !int_config_q[sil_pkg::CFG_DRIVE_BIT]
    |=> int_pin_o == !$past(int_config_q[sil_pkg::CFG_POL_BIT]))
    else $error("disabled pin not idle");
  fifo_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    full_prev_q && !fifo_full_cond && !meas_done |=> !full_prev_q)
    else $error("full condition not released");
  sticky_win_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    status_q[sil_pkg::SRC_WIN] && !stat_rd && !flush_any
    |=> status_q[sil_pkg::SRC_WIN])
    else $error("window status cleared on its own");

endmodule

// file: verification/sil_host_model.sv
// Host-side model that resolves the interrupt line and times its pulses.
`timescale 1ns/1ps
module sil_host_model (
  // Clock
  input wire logic sys_clk,
  // Pin as driven by the block
  input wire logic int_pin_o,
  input wire logic int_pin_oe_n,
  // Level that the host reads as asserted
  input wire logic active_high,
  // Host view of the line
  output logic int_line,
  output logic asserted,
  output int n_pulse,
  output int width,
  output int gap
);
  int run_q;
  logic prev_q;

  // The board pulls the line up, so a released open-drain pin reads high.
  assign int_line = int_pin_oe_n ? 1'b1 : int_pin_o;
  assign asserted = (int_line === active_high);

  // Counters start clean so the first gap is simply long.
  initial
  begin
    run_q = 0;
    prev_q = 1'b0;
    n_pulse = 0;
    width = 0;
    gap = 0;
  end

  // Every assertion and every gap is timed in whole clock cycles.
  always @(posedge sys_clk)
  begin
    if (asserted != prev_q)
    begin
      if (prev_q)
        width <= run_q;
      else
      begin
        gap <= run_q;
        n_pulse <= n_pulse + 1;
      end
      run_q <= 1;
    end
    else
      run_q <= run_q + 1;
    prev_q <= asserted;
  end
endmodule

// file: verification/sil_top_tb.sv
// Self-checking testbench for the sensor interrupt logic.
`timescale 1ns/1ps
module sil_top_tb;
  logic sys_clk, nrst, reg_wr, reg_rd, meas_done, act_hi;
  logic fifo_full_cond, fifo_ths_cond, fifo_enabled, fifo_flush;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_ths_q;
  logic [16:0] meas_press;
  logic int_pin_o, int_pin_oe_n, int_line, asserted;
  int n_pulse, width, gap, n_errors, compares;

  sil_top sil_top_i (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .meas_done(meas_done), .meas_press(meas_press),
    .fifo_full_cond(fifo_full_cond), .fifo_ths_cond(fifo_ths_cond),
    .fifo_enabled(fifo_enabled), .fifo_flush(fifo_flush),
    .int_pin_o(int_pin_o), .int_pin_oe_n(int_pin_oe_n),
    .fifo_ths_q(fifo_ths_q));

  sil_host_model sil_host_model_i (.sys_clk(sys_clk), .int_pin_o(int_pin_o),
    .int_pin_oe_n(int_pin_oe_n), .active_high(act_hi), .int_line(int_line),
    .asserted(asserted), .n_pulse(n_pulse), .width(width), .gap(gap));

  // Free-running 10 MHz clock.
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic stat(output logic [7:0] d);
    rd(sil_pkg::ADDR_INT_STATUS, d);
  endtask

  task automatic meas(input logic [16:0] p);
    @(posedge sys_clk);
    meas_done <= 1'b1;
    meas_press <= p;
    @(posedge sys_clk);
    meas_done <= 1'b0;
    cyc(3);
  endtask

  // Sources off and status cleared before the mode changes.
  task automatic sw_mode(input logic [7:0] cfg);
    logic [7:0] d;
    wr(sil_pkg::ADDR_INT_SOURCE, 8'h00);
    stat(d);
    wr(sil_pkg::ADDR_INT_CONFIG, cfg);
    cyc(2);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    stat(d);
    chk(d[4], 1'b1, "power-up flag");
    chk(asserted, 1'b0, "pin quiet after power-up");
    stat(d);
    chk(d[4], 1'b0, "power-up flag cleared");
    rd(sil_pkg::ADDR_INT_CONFIG, d);
    chk(d, sil_pkg::INT_CONFIG_RST, "config reset");
    rd(sil_pkg::ADDR_INT_SOURCE, d);
    chk(d, sil_pkg::INT_SOURCE_RST, "source reset");
    rd(sil_pkg::ADDR_WIN_CONFIG, d);
    chk(d, sil_pkg::WIN_CONFIG_RST, "window config reset");
    wr(8'h20, 8'h5A);
    rd(8'h20, d);
    chk(d, 8'h00, "unmapped address");
    $display("test reset done");
  endtask

  task automatic t_window();
    logic [7:0] d;
    logic [16:0] seq [5] = '{17'd97201, 17'd97200, 17'd97099, 17'd97100,
                             17'd97201};
    wr(sil_pkg::ADDR_WIN_CONFIG, 8'h82);
    wr(sil_pkg::ADDR_WIN_REF_MSB, 8'h7B);
    wr(sil_pkg::ADDR_WIN_REF_LSB, 8'h7E);
    wr(sil_pkg::ADDR_WIN_RANGE, 8'h32);
    rd(sil_pkg::ADDR_WIN_CONFIG, d);
    chk(d, 8'h82, "reference top bit and limit");
    rd(sil_pkg::ADDR_WIN_RANGE, d);
    chk(d, 8'h32, "half width");
    wr(sil_pkg::ADDR_INT_SOURCE, 8'h08);
    // Samples on the window edges are inside and break the first two runs.
    foreach (seq[i])
      meas(seq[i]);
    stat(d);
    chk(d[3], 1'b0, "broken runs");
    meas(17'd97099);
    stat(d);
    chk(d[3], 1'b1, "two outside samples");
    meas(17'd97201);
    stat(d);
    chk(d[3], 1'b1, "refire");
    $display("test window done");
  endtask

  task automatic t_pulsed();
    logic [7:0] d;
    int n0;
    sw_mode(8'h0A);
    act_hi = 1'b1;
    wr(sil_pkg::ADDR_INT_SOURCE, 8'h01);
    cyc(8);
    chk(int_pin_oe_n, 1'b0, "push-pull drives");
    n0 = n_pulse;
    meas(17'd97150);
    chk(asserted, 1'b1, "pulse on new data");
    stat(d);
    cyc(3);
    // Second event lands inside the gap after the first pulse.
    meas(17'd97150);
    cyc(20);
    chk(n_pulse - n0, 2, "pulse count");
    chk(width, 5, "pulse length");
    chk(gap >= 5, 1, "gap between pulses");
    $display("test pulsed done");
  endtask

  task automatic t_latched();
    logic [7:0] d;
    sw_mode(8'h0F);
    wr(sil_pkg::ADDR_INT_SOURCE, 8'h02);
    @(posedge sys_clk);
    fifo_full_cond <= 1'b1;
    meas(17'd97150);
    cyc(8);
    chk(asserted, 1'b1, "full held");
    stat(d);
    chk(d[1], 1'b1, "full status");
    cyc(3);
    chk(asserted, 1'b1, "full ignores read");
    @(posedge sys_clk);
    fifo_full_cond <= 1'b0;
    cyc(3);
    chk(asserted, 1'b0, "full released");
    stat(d);
    chk(d[1], 1'b1, "full status kept");
    stat(d);
    chk(d[1], 1'b0, "full status cleared");
    wr(sil_pkg::ADDR_INT_SOURCE, 8'h01);
    meas(17'd97150);
    cyc(8);
    chk(asserted, 1'b1, "ready held");
    stat(d);
    chk(d[0], 1'b1, "ready status");
    cyc(3);
    chk(asserted, 1'b0, "ready released by read");
    $display("test latched done");
  endtask

  task automatic t_flush();
    logic [7:0] d;
    wr(sil_pkg::ADDR_INT_SOURCE, 8'h04);
    @(posedge sys_clk);
    fifo_ths_cond <= 1'b1;
    meas(17'd97150);
    chk(asserted, 1'b1, "threshold asserted");
    wr(sil_pkg::ADDR_FIFO_THS, 8'h05);
    cyc(2);
    chk(asserted, 1'b0, "threshold write releases");
    chk(fifo_ths_q, 8'h05, "threshold value");
    cyc(1);
    chk(asserted, 1'b0, "gap before reassert");
    cyc(6);
    chk(asserted, 1'b1, "threshold reasserted");
    @(posedge sys_clk);
    fifo_enabled <= 1'b0;
    cyc(2);
    chk(asserted, 1'b0, "disable releases");
    stat(d);
    chk(d[2], 1'b0, "disable clears status");
    @(posedge sys_clk);
    fifo_enabled <= 1'b1;
    fifo_ths_cond <= 1'b0;
    wr(sil_pkg::ADDR_INT_SOURCE, 8'h08);
    cyc(8);
    stat(d);
    meas(17'd97201);
    meas(17'd97201);
    chk(asserted, 1'b1, "window asserted");
    @(posedge sys_clk);
    fifo_flush <= 1'b1;
    @(posedge sys_clk);
    fifo_flush <= 1'b0;
    cyc(1);
    chk(asserted, 1'b0, "flush releases window");
    stat(d);
    chk(d[3], 1'b0, "flush clears window status");
    $display("test flush done");
  endtask

  task automatic close_out();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Reset for ten cycles, then run every scenario in turn.
  initial
  begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    {reg_wr, reg_rd, meas_done, fifo_flush, act_hi} = 5'h00;
    {fifo_full_cond, fifo_ths_cond} = 2'h0;
    fifo_enabled = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    meas_press = 17'h00000;
    n_errors = 0;
    compares = 0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    cyc(2);
    t_reset();
    t_window();
    t_pulsed();
    t_latched();
    t_flush();
    close_out();
  end

  // The scenarios take well under a thousand cycles; a hang ends here.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
